// ---- hw/acc_regs.svh ----
// register map, field positions, reset values and timing counts
`ifndef ACC_REGS_SVH
`define ACC_REGS_SVH
`define ACC_ADDR_CTRL 32'hffff0500
`define ACC_ADDR_STAT 32'hffff050c
`define ACC_ADDR_DATA 32'hffff0510
`define ACC_CTRL_RESET 16'h0600
`define ACC_CTRL_WMASK 16'h3fbf
`define ACC_BIT_TEMP 13
`define ACC_DIV_HI 12
`define ACC_DIV_LO 10
`define ACC_ACQ_HI 9
`define ACC_ACQ_LO 8
`define ACC_BIT_EN 7
`define ACC_BIT_PWR 5
`define ACC_MODE_HI 4
`define ACC_MODE_LO 3
`define ACC_TYPE_HI 2
`define ACC_TYPE_LO 0
`define ACC_STAT_READY 0
`define ACC_STAT_BUSY 1
`define ACC_STAT_PWROK 2
`define ACC_STAT_TEMP 3
`define ACC_TEMP_DIV 3'h5
`define ACC_TEMP_ACQ 2'h3
`define ACC_EXTRA_CLKS 6'h13
`define ACC_CLK_NS 4
`define ACC_PWRUP_NS 5000
`define ACC_PWRUP_CYC ((`ACC_PWRUP_NS + `ACC_CLK_NS - 1) / `ACC_CLK_NS)
`endif

// ---- hw/acc_pkg.sv ----
// types shared by the conversion control modules
package acc_pkg;
  typedef enum logic [2:0] {
    ACC_TRIG_PIN = 3'h0,
    ACC_TRIG_FIRST_TIMER_OVERFLOW = 3'h1,
    ACC_TRIG_SECOND_TIMER_OVERFLOW = 3'h2,
    ACC_TRIG_SINGLE = 3'h3,
    ACC_TRIG_CONT = 3'h4,
    ACC_TRIG_LOGIC = 3'h5
  } acc_trig_e;
  typedef enum logic [1:0] {
    ACC_MODE_SINGLE_ENDED = 2'h0,
    ACC_MODE_DIFF = 2'h1
  } acc_mode_e;
  typedef enum logic [1:0] {
    ACC_ST_IDLE = 2'b00,
    ACC_ST_ACQ = 2'b01,
    ACC_ST_CONV = 2'b11
  } acc_state_e;
  typedef struct packed {
    logic [15:0] ctrl;
    logic [31:0] result;
    logic ready;
    acc_state_e state;
    logic [5:0] cnt;
    logic temp_act;
    logic cont_run;
    logic [10:0] pwr_cnt;
    logic pwr_ok;
    logic a_valid;
    logic a_write;
    logic a_ctrl;
    logic [31:0] rdata;
    logic pin_s1;
    logic pin_s2;
    logic pin_s3;
  } acc_top_s;
  typedef struct packed {
    logic [4:0] cnt;
  } acc_div_s;
endpackage : acc_pkg

// ---- hw/acc_res_if.sv ----
// carrier between the sequencer and the result formatter
interface acc_res_if;
  logic [11:0] raw;
  logic diff;
  logic [31:0] word;
  modport fmt (input raw, input diff, output word);
  modport user (output raw, output diff, input word);
endinterface : acc_res_if

// ---- hw/acc_clkdiv.sv ----
// converter clock divider producing one tick per converter clock
module acc_clkdiv (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic run,
  input wire logic [2:0] code,
  output logic tick
);
  acc_pkg::acc_div_s s;
  acc_pkg::acc_div_s n;
  logic [4:0] limit;

  always_comb begin
    // codes above 101 are reserved and run as the slowest divider
    if (code > 3'h5) begin
      limit = 5'h1f;
    end else begin
      limit = 5'((6'h01 << code) - 6'h01);
    end
    tick = run && (s.cnt >= limit);
    n = s;
    if (!run || tick) begin
      n.cnt = 5'h00;
    end else begin
      n.cnt = s.cnt + 5'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end
endmodule : acc_clkdiv

// ---- hw/acc_fmt.sv ----
// result formatter: places the code in the 32-bit result word
module acc_fmt (
  acc_res_if.fmt res
);
  logic [11:0] code;
  logic sign;

  always_comb begin
    if (res.diff) begin
      code = {~res.raw[11], res.raw[10:0]};
      sign = code[11];
    end else begin
      code = res.raw;
      sign = 1'b0;
    end
    res.word = {{4{sign}}, code, 16'h0000};
  end
endmodule : acc_fmt

// ---- hw/acc_ctrl.sv ----
// conversion control: register file, trigger selection and sequencing
`include "acc_regs.svh"

// Function
// - single-ended results are coded as unsigned straight binary
// - differential results are coded in twos complement, signed field
// - the 12-bit result sits in bits 16 to 27 of the word
// - the top four bits of the word carry the sign
// - a conversion lasts acquisition clocks plus 19 extra clocks
// - temperature timing reverts to user timing once its result is read
// - control bit 13 selects temperature timing and masks the pin trigger
// - bits 12 to 10 divide converter clock by 1 to 32, default /2
// - bits 9 to 8 set acquisition 2 to 16 clocks, default 8
// - bit 7 must be set for a conversion to start, except a continuous restart
// - clearing bit 7 does not stop continuous conversion
// - bit 5 powers the converter; wait 5 us before converting
// - bits 4 to 3 select single-ended or differential mode
// - bits 2 to 0 choose pin, timers, software or logic trigger
// - a finished single software conversion resets the type field to 000
// - pin, logic output and timer overflows retrigger on every event that arrives while idle
module acc_ctrl (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic external_trigger_pin,
  input wire logic first_timer_overflow,
  input wire logic second_timer_overflow,
  input wire logic logic_array_trigger,
  input wire logic temp_channel_sel,
  input wire logic [11:0] core_result,
  output logic core_power,
  output logic core_diff,
  output logic core_tick,
  output logic core_acquire,
  output logic core_convert,
  output logic result_ready
);
  acc_pkg::acc_top_s s;
  acc_pkg::acc_top_s n;
  acc_res_if res ();

  logic [2:0] div_code;
  logic [1:0] acq_code;
  logic [5:0] acq_len;
  logic [2:0] ctype;
  logic enable;
  logic powered;
  logic pin_rise;
  logic trig;
  logic start;
  logic tick;
  logic busy;
  logic take;
  logic rd_data;
  logic [15:0] wr_val;

  acc_clkdiv u_div (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(busy),
    .code(div_code),
    .tick(tick)
  );

  acc_fmt u_fmt (
    .res(res.fmt)
  );

  assign res.raw = core_result;
  assign res.diff = (s.ctrl[`ACC_MODE_HI:`ACC_MODE_LO] ==
    acc_pkg::ACC_MODE_DIFF);

  always_comb begin
    ctype = s.ctrl[`ACC_TYPE_HI:`ACC_TYPE_LO];
    enable = s.ctrl[`ACC_BIT_EN];
    powered = s.ctrl[`ACC_BIT_PWR];
    busy = (s.state != acc_pkg::ACC_ST_IDLE);
    // temperature timing overrides the user fields while active
    if (s.ctrl[`ACC_BIT_TEMP] || s.temp_act) begin
      div_code = `ACC_TEMP_DIV;
      acq_code = `ACC_TEMP_ACQ;
    end else begin
      div_code = s.ctrl[`ACC_DIV_HI:`ACC_DIV_LO];
      acq_code = s.ctrl[`ACC_ACQ_HI:`ACC_ACQ_LO];
    end
    acq_len = 6'((7'h02 << acq_code));
    pin_rise = s.pin_s2 && !s.pin_s3;
    trig = 1'b0;
    unique case (ctype)
      acc_pkg::ACC_TRIG_PIN: begin
        trig = pin_rise && !s.ctrl[`ACC_BIT_TEMP];
      end
      acc_pkg::ACC_TRIG_FIRST_TIMER_OVERFLOW: begin
        trig = first_timer_overflow;
      end
      acc_pkg::ACC_TRIG_SECOND_TIMER_OVERFLOW: begin
        trig = second_timer_overflow;
      end
      acc_pkg::ACC_TRIG_SINGLE: begin
        trig = 1'b1;
      end
      acc_pkg::ACC_TRIG_CONT: begin
        trig = 1'b1;
      end
      acc_pkg::ACC_TRIG_LOGIC: begin
        trig = logic_array_trigger;
      end
      default: begin
        trig = 1'b0;
      end
    endcase
    // continuous mode keeps restarting even after the enable clears
    start = !busy && powered &&
      ((enable && trig) || s.cont_run);
    take = hsel && htrans[1] && hready;
    rd_data = take && !hwrite && (haddr == `ACC_ADDR_DATA);
    wr_val = hwdata[15:0] & `ACC_CTRL_WMASK;
  end

  always_comb begin
    n = s;
    // pin synchroniser and edge history
    n.pin_s1 = external_trigger_pin;
    n.pin_s2 = s.pin_s1;
    n.pin_s3 = s.pin_s2;

    // power-up settling count
    if (!powered) begin
      n.pwr_cnt = 11'h000;
      n.pwr_ok = 1'b0;
    end else if (s.pwr_cnt >= 11'(`ACC_PWRUP_CYC - 1)) begin
      n.pwr_ok = 1'b1;
    end else begin
      n.pwr_cnt = s.pwr_cnt + 11'h001;
    end

    // continuous run state
    if (!powered || ctype != acc_pkg::ACC_TRIG_CONT) begin
      n.cont_run = 1'b0;
    end else if (enable) begin
      n.cont_run = 1'b1;
    end

    // conversion sequencer
    unique case (s.state)
      acc_pkg::ACC_ST_IDLE: begin
        if (start) begin
          n.state = acc_pkg::ACC_ST_ACQ;
          n.cnt = 6'h00;
          if (temp_channel_sel) begin
            n.temp_act = 1'b1;
          end
        end
      end
      acc_pkg::ACC_ST_ACQ: begin
        if (tick) begin
          if (s.cnt + 6'h01 >= acq_len) begin
            n.state = acc_pkg::ACC_ST_CONV;
            n.cnt = 6'h00;
          end else begin
            n.cnt = s.cnt + 6'h01;
          end
        end
      end
      acc_pkg::ACC_ST_CONV: begin
        if (tick) begin
          if (s.cnt + 6'h01 >= `ACC_EXTRA_CLKS) begin
            n.state = acc_pkg::ACC_ST_IDLE;
            n.cnt = 6'h00;
            n.result = res.word;
            n.ready = 1'b1;
            if (ctype == acc_pkg::ACC_TRIG_SINGLE) begin
              n.ctrl[`ACC_TYPE_HI:`ACC_TYPE_LO] = 3'h0;
            end
          end else begin
            n.cnt = s.cnt + 6'h01;
          end
        end
      end
      default: begin
        n.state = acc_pkg::ACC_ST_IDLE;
      end
    endcase

    // power down abandons a conversion in flight
    if (!powered) begin
      n.state = acc_pkg::ACC_ST_IDLE;
      n.cnt = 6'h00;
    end

    // reading the result clears ready unless the conversion phase ends now
    if (rd_data) begin
      if (!(s.state == acc_pkg::ACC_ST_CONV && n.state ==
          acc_pkg::ACC_ST_IDLE)) begin
        n.ready = 1'b0;
      end
      if (!(s.state == acc_pkg::ACC_ST_IDLE && start &&
          temp_channel_sel)) begin
        n.temp_act = 1'b0;
      end
    end

    // bus data phase: control write
    if (s.a_valid && s.a_write && s.a_ctrl) begin
      n.ctrl = wr_val;
    end

    // bus address phase
    n.a_valid = take;
    n.a_write = hwrite;
    n.a_ctrl = (haddr == `ACC_ADDR_CTRL);
    n.rdata = 32'h0000_0000;
    if (take && !hwrite) begin
      if (haddr == `ACC_ADDR_CTRL) begin
        n.rdata = {16'h0000, n.ctrl};
      end else if (haddr == `ACC_ADDR_STAT) begin
        n.rdata[`ACC_STAT_READY] = s.ready;
        n.rdata[`ACC_STAT_BUSY] = busy;
        n.rdata[`ACC_STAT_PWROK] = s.pwr_ok;
        n.rdata[`ACC_STAT_TEMP] = s.temp_act;
      end else if (haddr == `ACC_ADDR_DATA) begin
        n.rdata = s.result;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
      s.ctrl <= `ACC_CTRL_RESET;
      s.state <= acc_pkg::ACC_ST_IDLE;
    end else begin
      s <= n;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s.rdata;
  assign core_power = powered;
  assign core_diff = res.diff;
  assign core_tick = tick;
  assign core_acquire = (s.state == acc_pkg::ACC_ST_ACQ);
  assign core_convert = (s.state == acc_pkg::ACC_ST_CONV);
  assign result_ready = s.ready;
endmodule : acc_ctrl

// ---- verification/acc_core_model.sv ----
// behavioural model of the input multiplexer and converter core
module acc_core_model (
  input wire logic hclk,
  input wire logic core_power,
  input wire logic core_convert,
  input wire logic [11:0] code,
  input wire logic temp,
  output logic [11:0] core_result,
  output logic temp_channel_sel
);
  timeunit 1ns;
  timeprecision 1ps;
  initial core_result = 12'h5a5;
  // outside a conversion the code lines toggle every cycle
  always @(posedge hclk) begin
    core_result <= (core_convert & core_power) ? code : ~core_result;
  end
  assign temp_channel_sel = temp;
endmodule : acc_core_model

// ---- verification/acc_chk.sv ----
// checker for the conversion sequencing seen at the block's ports
`include "acc_regs.svh"
module acc_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic core_power,
  input wire logic core_tick,
  input wire logic core_acquire,
  input wire logic core_convert,
  input wire logic result_ready
);
  logic [4:0] n;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ticks counted within the current phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) n <= 5'h00;
    else if ($changed({core_acquire, core_convert})) n <= {4'h0, core_tick};
    else n <= n + {4'h0, core_tick};
  end
  sequence s_acq_end;
    $fell(core_acquire) && core_power;
  endsequence
  sequence s_conv_end;
    $fell(core_convert) && core_power;
  endsequence
  sequence s_off;
    !core_power [*2];
  endsequence
  AST_TICK_BUSY: assert property (core_tick |-> core_acquire || core_convert)
    else $error("tick while idle");
  AST_PHASE_EXCL: assert property (!(core_acquire && core_convert))
    else $error("both phases");
  AST_ACQ_LEN: assert property (s_acq_end |-> n inside {2, 4, 8, 16})
    else $error("bad acquisition length");
  AST_ACQ_TO_CONV: assert property (s_acq_end |-> core_convert)
    else $error("no bit trials");
  AST_CONV_LEN: assert property (s_conv_end |-> n == 5'h13)
    else $error("bad trial length");
  AST_READY_END: assert property (s_conv_end |-> result_ready)
    else $error("no ready");
  AST_POWER_OFF: assert property (s_off |-> !core_acquire && !core_convert)
    else $error("busy unpowered");
  AST_START_POWERED: assert property ($rose(core_acquire) |-> $past(core_power))
    else $error("start unpowered");
  AST_READY_HOLD: assert property (result_ready && !(hsel && htrans[1] &&
    !hwrite && haddr == `ACC_ADDR_DATA) |=> result_ready)
    else $error("ready lost");
endmodule : acc_chk
bind acc_ctrl acc_chk u_chk (.*);

// ---- verification/testbench.sv ----
// register-level bench for the conversion control block
`include "acc_regs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hready, hreadyout, hresp, temp_channel_sel, core_power, core_diff;
  logic [31:0] hrdata, rv;
  logic external_trigger_pin = 1'b0;
  logic first_timer_overflow = 1'b0;
  logic second_timer_overflow = 1'b0;
  logic logic_array_trigger = 1'b0;
  logic core_tick, core_acquire, core_convert, result_ready;
  logic [11:0] core_result;
  logic [11:0] code = 12'h000;
  logic temp = 1'b0;
  logic [15:0] cv;
  int bad_count = 0, tests_run = 0, na = 0, nc = 0, cc = 0, ca = 0;
  logic [2:0] typ [6] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h3, 3'h4};
  logic [11:0] cds [6] = '{12'hfff, 12'h000, 12'h7ff, 12'h800, 12'h123, 12'hedc};
  assign hready = hreadyout;
  always #2 hclk = ~hclk;
  acc_ctrl DUT (.*);
  acc_core_model u_core (.*);
  always @(posedge hclk) begin
    ca += int'(core_acquire);
    na += int'(core_acquire & core_tick);
    cc += int'(core_convert);
    nc += int'(core_convert & core_tick);
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge hclk);
    while (!hready) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (!hready) @(posedge hclk);
    rv = hrdata;
  endtask : xfer
  task wait_rdy;
    int k;
    k = 0;
    while (result_ready !== 1'b1 && k < 3000) begin
      @(posedge hclk);
      k++;
    end
    chk({31'h0, result_ready}, 32'h1);
  endtask : wait_rdy
  task fire(input logic [2:0] t);
    @(posedge hclk);
    case (t)
      3'h0: external_trigger_pin <= 1'b1;
      3'h1: first_timer_overflow <= 1'b1;
      3'h2: second_timer_overflow <= 1'b1;
      3'h5: logic_array_trigger <= 1'b1;
      default: ;
    endcase
    @(posedge hclk);
    first_timer_overflow <= 1'b0;
    second_timer_overflow <= 1'b0;
    logic_array_trigger <= 1'b0;
  endtask : fire
  function automatic logic [31:0] fmt(input logic [11:0] c, input logic d);
    logic [11:0] v;
    v = d ? {~c[11], c[10:0]} : c;
    return {{4{d & v[11]}}, v, 16'h0000};
  endfunction : fmt
  task results;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results
  initial begin
    #200000;
    bad_count++;
    results();
  end
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    xfer(1'b0, `ACC_ADDR_CTRL, 32'h0);
    chk(rv, 32'h00000600);
    chk({31'h0, core_power}, 32'h0);
    xfer(1'b1, `ACC_ADDR_CTRL, 32'hffffffff);
    xfer(1'b0, `ACC_ADDR_CTRL, 32'h0);
    chk(rv, 32'h00003fbf);
    xfer(1'b0, 32'hffff0520, 32'h0);
    chk(rv, 32'h0);
    xfer(1'b1, `ACC_ADDR_CTRL, 32'h00000021);
    ca = 0;
    fire(3'h1);
    repeat (40) @(posedge hclk);
    chk(32'(ca), 32'h0);
    for (int i = 0; i < 6; i++) begin
      logic [2:0] dv;
      logic [1:0] aq;
      dv = (i == 4) ? 3'h5 : 3'(i);
      aq = (i == 4) ? 2'h3 : 2'(i % 4);
      cv = {3'h0, 3'(i), 2'(i % 4), 3'h5, 1'b0, i[0], typ[i]};
      if (i == 4) cv = 16'h37a3;
      code <= cds[i];
      temp <= (i == 4);
      na = 0;
      nc = 0;
      cc = 0;
      xfer(1'b1, `ACC_ADDR_CTRL, {16'h0, cv});
      fire(typ[i]);
      wait_rdy();
      chk(32'(na), 32'd2 << aq);
      chk(32'(nc), 32'd19);
      chk(32'(cc), 32'd19 << dv);
      chk({31'h0, core_diff}, {31'h0, i[0]});
      xfer(1'b0, `ACC_ADDR_DATA, 32'h0);
      chk(rv, fmt(cds[i], i[0]));
      external_trigger_pin <= 1'b0;
      if (i == 4) begin
        xfer(1'b0, `ACC_ADDR_CTRL, 32'h0);
        chk(rv, 32'h000037a0);
      end
    end
    xfer(1'b1, `ACC_ADDR_CTRL, {16'h0, cv & 16'hff7f});
    wait_rdy();
    xfer(1'b0, `ACC_ADDR_DATA, 32'h0);
    wait_rdy();
    xfer(1'b0, `ACC_ADDR_STAT, 32'h0);
    chk(rv & 32'h4, 32'h4);
    chk({31'h0, hresp}, 32'h0);
    xfer(1'b1, `ACC_ADDR_CTRL, 32'h0);
    // the control write lands at the last edge of the task
    @(posedge hclk);
    chk({31'h0, core_power}, 32'h0);
    @(posedge hclk);
    chk({30'h0, core_acquire, core_convert}, 32'h0);
    results();
  end
endmodule : testbench
